// *** hdl/pmcs_calc.sv ***
// Current and power computation with sample accumulators
`timescale 1ns/1ns
`default_nettype none
module pmcs_calc (
  input wire logic   sys_clk,
  input wire logic   resetn,
  pmcs_calc_if.calc  cif
);
  import pmcs_pkg::*;

  logic signed [ACC_W-1:0] s_sh;
  logic signed [ACC_W-1:0] s_bu;
  logic signed [ACC_W-1:0] s_cu;
  logic signed [ACC_W-1:0] s_pw;
  logic signed [ACC_W-1:0] next_s_sh;
  logic signed [ACC_W-1:0] next_s_bu;
  logic signed [ACC_W-1:0] next_s_cu;
  logic signed [ACC_W-1:0] next_s_pw;
  logic signed [15:0]      cur;
  logic signed [15:0]      next_cur;
  logic signed [32:0]      prod_c;
  logic signed [32:0]      prod_p;
  logic signed [15:0]      cur_new;
  logic signed [15:0]      pwr_new;

  always_comb
  begin
    prod_c = $signed(cif.sample) * $signed({1'b0, cif.cal});
    prod_p = cur * $signed({1'b0, cif.sample});
    // Calibration of zero forces both derived results to zero [R20]
    cur_new = (cif.cal == 16'h0000) ? 16'sh0000
                                    : 16'(prod_c >>> CUR_SHIFT); // [R19]
    pwr_new = (cif.cal == 16'h0000) ? 16'sh0000
                                    : 16'(prod_p >>> PWR_SHIFT);
    next_s_sh = s_sh;
    next_s_bu = s_bu;
    next_s_cu = s_cu;
    next_s_pw = s_pw;
    next_cur  = cur;
    if (cif.clear)
    begin
      next_s_sh = '0;
      next_s_bu = '0;
      next_s_cu = '0;
      next_s_pw = '0;
    end
    else if (cif.shunt_vld)
    begin
      // Current follows each shunt sample in the same cycle [R3] [R9]
      next_cur  = cur_new;
      next_s_sh = s_sh + ACC_W'($signed(cif.sample)); // [R4]
      next_s_cu = s_cu + ACC_W'(cur_new);
    end
    else if (cif.bus_vld)
    begin
      // Power uses the latest current and the new bus sample [R3]
      next_s_bu = s_bu + $signed(ACC_W'(cif.sample)); // [R4]
      next_s_pw = s_pw + ACC_W'(pwr_new);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_sh <= '0;
      s_bu <= '0;
      s_cu <= '0;
      s_pw <= '0;
      cur  <= '0;
    end
    else
    begin
      s_sh <= next_s_sh;
      s_bu <= next_s_bu;
      s_cu <= next_s_cu;
      s_pw <= next_s_pw;
      cur  <= next_cur;
    end
  end

  assign cif.avg_shunt = 16'(s_sh >>> cif.shift);
  assign cif.avg_bus   = 16'(s_bu >>> cif.shift);
  assign cif.avg_cur   = 16'(s_cu >>> cif.shift);
  assign cif.avg_pwr   = 16'(s_pw >>> cif.shift);
endmodule
`default_nettype wire

// *** hdl/pmcs_calc_if.sv ***
// Link between the sequencer and its arithmetic unit
`timescale 1ns/1ns
`default_nettype none
interface pmcs_calc_if;
  logic        clear;
  logic        shunt_vld;
  logic        bus_vld;
  logic [15:0] sample;
  logic [15:0] cal;
  logic [3:0]  shift;
  logic [15:0] avg_shunt;
  logic [15:0] avg_bus;
  logic [15:0] avg_cur;
  logic [15:0] avg_pwr;
  modport seq  (output clear, shunt_vld, bus_vld, sample, cal, shift,
                input avg_shunt, avg_bus, avg_cur, avg_pwr);
  modport calc (input clear, shunt_vld, bus_vld, sample, cal, shift,
                output avg_shunt, avg_bus, avg_cur, avg_pwr);
endinterface
`default_nettype wire

// *** hdl/pmcs_pkg.sv ***
// Shared constants of the power monitor conversion sequencer
package pmcs_pkg;
  localparam logic [7:0]  ADDR_CFG   = 8'h00;
  localparam logic [7:0]  ADDR_SHUNT = 8'h01;
  localparam logic [7:0]  ADDR_BUS   = 8'h02;
  localparam logic [7:0]  ADDR_PWR   = 8'h03;
  localparam logic [7:0]  ADDR_CUR   = 8'h04;
  localparam logic [7:0]  ADDR_CAL   = 8'h05;
  localparam logic [7:0]  ADDR_MASK  = 8'h06;
  localparam logic [15:0] CFG_RESET  = 16'h0007;
  localparam logic [15:0] CAL_RESET  = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] MASK_RW    = 16'hFC03;
  localparam int          MODE_LSB   = 0;
  localparam int          SCT_LSB    = 3;
  localparam int          BCT_LSB    = 6;
  localparam int          AVG_LSB    = 9;
  localparam int          MASK_FLAG_BIT = 3;
  localparam int          MODE_SHUNT_BIT = 0;
  localparam int          MODE_BUS_BIT   = 1;
  localparam int          MODE_CONT_BIT  = 2;
  localparam logic [3:0]  AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6,
                                            4'h7, 4'h8, 4'h9, 4'hA};
  localparam int          CUR_SHIFT  = 11;
  localparam int          PWR_SHIFT  = 13;
  localparam int          ACC_W      = 28;
  localparam int          CLK_MHZ    = 100;
  localparam int          WAKE_US    = 40;
  localparam int          WAKE_CYC   = WAKE_US * CLK_MHZ;
  localparam int          SCL_TIMEOUT_MS  = 28;
  localparam int          SCL_TIMEOUT_CYC = SCL_TIMEOUT_MS * CLK_MHZ * 1000;
  typedef enum logic [2:0] {ST_IDLE, ST_WAKE, ST_SHUNT, ST_BUS, ST_FINISH,
                            ST_LOAD} pmcs_state_t;
endpackage

// *** hdl/pmcs_top.sv ***
// Conversion sequencer, register file and serial-clock timeout
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1: Serial clock low over 28 ms resets interface
// R2: Mode 111 repeats shunt then bus conversions
// R3: Current after shunt sample, then power
// R4: Accumulate samples until averaging count reached
// R5: Output registers load only after averaging
// R6: Outputs hold until next complete result set
// R7: Register reads never disturb a conversion
// R8: Modes for shunt only or bus only
// R9: Computation adds no conversion time
// R10: Modes 001, 010, 011 start one set
// R11: Host rewrites configuration for another set
// R12: Leaving power-down waits 40 us first (an active-mode write during the wait starts conversions at once)
// R13: Registers accessible during power-down
// R14: Power-down holds until active mode written
// R15: Ready flag set when everything completes
// R16: Configuration write clears flag unless power-down
// R17: Reading mask register clears ready flag
// R18: Bus result weight fixed 1.25 mV per bit
// R19: Current scaled by calibration value
// R20: Zero calibration gives zero current, power
// R21: Ready flag read at mask bit 3
// R22: Continuous mode restarts with cleared accumulators
// R23: Single shot runs once, then idles
module pmcs_top #(
  parameter int TIMEOUT_CYC = pmcs_pkg::SCL_TIMEOUT_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        scl_pin,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        adc_done,
  input  wire logic [15:0] adc_data,
  output logic             adc_start,
  output logic             adc_sel_bus,
  output logic      [2:0]  adc_conv_time,
  output logic             conversion_ready_flag,
  output logic             serial_if_reset
);
  import pmcs_pkg::*;
  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  pmcs_calc_if cif ();
  pmcs_calc u_calc (.sys_clk(sys_clk), .resetn(resetn), .cif(cif.calc));

  logic [15:0] cfg, cal, mask_bits, res_shunt, res_bus, res_cur, res_pwr;
  logic [15:0] next_cfg, next_cal, next_mask_bits, next_reg_rdata;
  logic [15:0] next_res_shunt, next_res_bus, next_res_cur, next_res_pwr;
  logic        next_flag;
  logic        wr_cfg, rd_mask;
  logic [2:0]  cfg_mode, wr_mode;

  pmcs_state_t state, next_state;
  logic [2:0]  run_mode, next_run_mode, imode;
  logic [11:0] wake_cnt, next_wake_cnt;
  logic [10:0] smp_cnt, next_smp_cnt;
  logic        next_adc_start, next_adc_sel_bus;
  logic [2:0]  next_adc_conv_time;
  logic        clear, next_clear, shunt_vld, next_shunt_vld;
  logic        bus_vld, next_bus_vld;
  logic [15:0] sample, next_sample, tsrc;
  logic        start_set, end_sample, issue, last_smp;

  logic          scl_s1, scl_s2, next_serial_if_reset;
  logic [TW-1:0] scl_cnt, next_scl_cnt;

  assign wr_cfg   = reg_wr && (reg_addr == ADDR_CFG);
  assign rd_mask  = reg_rd && (reg_addr == ADDR_MASK);
  assign cfg_mode = cfg[MODE_LSB +: 3];
  assign wr_mode  = reg_wdata[MODE_LSB +: 3];
  assign last_smp = smp_cnt ==
                    11'((12'h001 << AVG_SHIFT[cfg[AVG_LSB +: 3]]) - 12'h001);

  assign cif.clear     = clear;
  assign cif.shunt_vld = shunt_vld;
  assign cif.bus_vld   = bus_vld;
  assign cif.sample    = sample;
  assign cif.cal       = cal;
  assign cif.shift     = AVG_SHIFT[cfg[AVG_LSB +: 3]];

  // Register file; reads select data and a mask read clears the flag, so conversions run on [R7] [R13]
  always_comb
  begin
    next_cfg       = cfg;
    next_cal       = cal;
    next_mask_bits = mask_bits;
    next_res_shunt = res_shunt;
    next_res_bus   = res_bus;
    next_res_cur   = res_cur;
    next_res_pwr   = res_pwr;
    next_flag      = conversion_ready_flag;
    next_reg_rdata = reg_rdata;
    if (wr_cfg)
      next_cfg = reg_wdata;
    if (reg_wr && reg_addr == ADDR_CAL)
      next_cal = reg_wdata;
    if (reg_wr && reg_addr == ADDR_MASK)
      next_mask_bits = reg_wdata & MASK_RW;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_CFG:   next_reg_rdata = cfg;
        ADDR_SHUNT: next_reg_rdata = res_shunt;
        ADDR_BUS:   next_reg_rdata = res_bus;
        ADDR_PWR:   next_reg_rdata = res_pwr;
        ADDR_CUR:   next_reg_rdata = res_cur;
        ADDR_CAL:   next_reg_rdata = cal;
        ADDR_MASK:
        begin
          next_reg_rdata = mask_bits;
          next_reg_rdata[MASK_FLAG_BIT] = conversion_ready_flag; // [R21]
        end
        default:    next_reg_rdata = 16'h0000;
      endcase
    end
    if (wr_cfg && wr_mode[1:0] != 2'b00)
      next_flag = 1'b0; // [R16]
    if (rd_mask)
      next_flag = 1'b0; // [R17]
    if (state == ST_LOAD)
    begin
      // Results replace outputs only here, after averaging [R5] [R6]
      if (run_mode[MODE_SHUNT_BIT])
      begin
        next_res_shunt = cif.avg_shunt;
        next_res_cur   = cif.avg_cur;
      end
      if (run_mode[MODE_BUS_BIT])
      begin
        next_res_bus = cif.avg_bus; // Raw code at 1.25 mV per bit [R18]
        next_res_pwr = cif.avg_pwr;
      end
      next_flag = 1'b1; // Set wins over a clear in the same cycle [R15]
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg                   <= CFG_RESET;
      cal                   <= CAL_RESET;
      mask_bits             <= MASK_RESET;
      res_shunt             <= 16'h0000;
      res_bus               <= 16'h0000;
      res_cur               <= 16'h0000;
      res_pwr               <= 16'h0000;
      conversion_ready_flag <= 1'b0;
      reg_rdata             <= 16'h0000;
    end
    else
    begin
      cfg                   <= next_cfg;
      cal                   <= next_cal;
      mask_bits             <= next_mask_bits;
      res_shunt             <= next_res_shunt;
      res_bus               <= next_res_bus;
      res_cur               <= next_res_cur;
      res_pwr               <= next_res_pwr;
      conversion_ready_flag <= next_flag;
      reg_rdata             <= next_reg_rdata;
    end
  end

  // Conversion sequencer
  always_comb
  begin
    next_state         = state;
    next_run_mode      = run_mode;
    next_wake_cnt      = wake_cnt;
    next_smp_cnt       = smp_cnt;
    next_adc_start     = 1'b0;
    next_adc_sel_bus   = adc_sel_bus;
    next_adc_conv_time = adc_conv_time;
    next_clear         = 1'b0;
    next_shunt_vld     = 1'b0;
    next_bus_vld       = 1'b0;
    next_sample        = sample;
    start_set          = 1'b0;
    end_sample         = 1'b0;
    issue              = 1'b0;
    imode              = run_mode;
    tsrc               = wr_cfg ? reg_wdata : cfg;
    unique case (state)
      ST_IDLE: ;
      ST_WAKE:
        if (wake_cnt == 12'(WAKE_CYC - 1))
          start_set = 1'b1; // [R12]
        else
          next_wake_cnt = wake_cnt + 12'h001;
      ST_SHUNT:
        if (adc_done)
        begin
          next_sample    = adc_data;
          next_shunt_vld = 1'b1; // [R3]
          if (run_mode[MODE_BUS_BIT])
          begin
            // Bus conversion starts at once; math runs alongside [R2] [R9]
            next_adc_start     = 1'b1;
            next_adc_sel_bus   = 1'b1;
            next_adc_conv_time = cfg[BCT_LSB +: 3];
            next_state         = ST_BUS;
          end
          else
            end_sample = 1'b1; // [R8]
        end
      ST_BUS:
        if (adc_done)
        begin
          next_sample  = adc_data;
          next_bus_vld = 1'b1;
          end_sample   = 1'b1;
        end
      ST_FINISH: next_state = ST_LOAD;
      ST_LOAD:
        if (run_mode[MODE_CONT_BIT])
          start_set = 1'b1; // [R22]
        else
          next_state = ST_IDLE; // [R23]
    endcase
    if (end_sample)
    begin
      if (last_smp)
        next_state = ST_FINISH; // [R4]
      else
      begin
        next_smp_cnt = smp_cnt + 11'h001;
        issue        = 1'b1;
      end
    end
    if (start_set)
    begin
      imode         = cfg_mode;
      next_run_mode = cfg_mode;
      next_clear    = 1'b1;
      next_smp_cnt  = '0;
      issue         = 1'b1;
    end
    if (wr_cfg)
    begin
      next_adc_start = 1'b0;
      next_shunt_vld = 1'b0;
      next_bus_vld   = 1'b0;
      next_clear     = 1'b0;
      issue          = 1'b0;
      if (wr_mode[1:0] == 2'b00)
        next_state = ST_IDLE; // [R14]
      else if (cfg_mode[1:0] == 2'b00)
      begin
        next_state    = ST_WAKE; // [R12]
        next_wake_cnt = '0;
      end
      else
      begin
        // An active write while already active starts a fresh set at once, same mode or not [R10] [R11]
        imode         = wr_mode;
        next_run_mode = wr_mode;
        next_clear    = 1'b1;
        next_smp_cnt  = '0;
        issue         = 1'b1;
      end
    end
    if (issue)
    begin
      next_adc_start   = 1'b1;
      next_adc_sel_bus = !imode[MODE_SHUNT_BIT]; // [R8]
      next_adc_conv_time = imode[MODE_SHUNT_BIT] ? tsrc[SCT_LSB +: 3]
                                                 : tsrc[BCT_LSB +: 3];
      next_state = imode[MODE_SHUNT_BIT] ? ST_SHUNT : ST_BUS;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state         <= ST_WAKE;
      run_mode      <= 3'h0;
      wake_cnt      <= 12'h000;
      smp_cnt       <= 11'h000;
      adc_start     <= 1'b0;
      adc_sel_bus   <= 1'b0;
      adc_conv_time <= 3'h0;
      clear         <= 1'b0;
      shunt_vld     <= 1'b0;
      bus_vld       <= 1'b0;
      sample        <= 16'h0000;
    end
    else
    begin
      state         <= next_state;
      run_mode      <= next_run_mode;
      wake_cnt      <= next_wake_cnt;
      smp_cnt       <= next_smp_cnt;
      adc_start     <= next_adc_start;
      adc_sel_bus   <= next_adc_sel_bus;
      adc_conv_time <= next_adc_conv_time;
      clear         <= next_clear;
      shunt_vld     <= next_shunt_vld;
      bus_vld       <= next_bus_vld;
      sample        <= next_sample;
    end
  end

  // Serial clock low timeout
  always_comb
  begin
    next_scl_cnt = scl_cnt;
    next_serial_if_reset = 1'b0;
    if (scl_s2)
      next_scl_cnt = '0;
    else if (scl_cnt != TW'(TIMEOUT_CYC))
      next_scl_cnt = scl_cnt + TW'(1);
    if (!scl_s2 && scl_cnt == TW'(TIMEOUT_CYC - 1))
      next_serial_if_reset = 1'b1; // [R1]
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_s1          <= 1'b1;
      scl_s2          <= 1'b1;
      scl_cnt         <= '0;
      serial_if_reset <= 1'b0;
    end
    else
    begin
      scl_s1          <= scl_pin;
      scl_s2          <= scl_s1;
      scl_cnt         <= next_scl_cnt;
      serial_if_reset <= next_serial_if_reset;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_trig_write;
    wr_cfg && wr_mode[MODE_CONT_BIT] == 1'b0 && wr_mode[1:0] != 2'b00
      && cfg_mode[1:0] != 2'b00;
  endsequence
  sequence s_single_done;
    state == ST_LOAD && !run_mode[MODE_CONT_BIT] && !wr_cfg;
  endsequence

  chk_timeout_pulse: assert property ( // [R1]
    serial_if_reset |-> $past(scl_cnt) == TW'(TIMEOUT_CYC - 1) && !$past(scl_s2))
    else $error("timeout pulse without full low period");
  chk_flag_source: assert property ( // [R15]
    $rose(conversion_ready_flag) |-> $past(state) == ST_LOAD)
    else $error("ready flag set outside result load");
  chk_cfg_clear: assert property ( // [R16]
    wr_cfg && wr_mode[1:0] != 2'b00 && state != ST_LOAD
      |=> !conversion_ready_flag)
    else $error("configuration write did not clear flag");
  chk_mask_rd_clear: assert property ( // [R17]
    rd_mask && state != ST_LOAD |=> !conversion_ready_flag)
    else $error("mask read did not clear flag");
  chk_outputs_hold: assert property ( // [R6]
    state != ST_LOAD |=> $stable(res_shunt) && $stable(res_bus)
      && $stable(res_cur) && $stable(res_pwr))
    else $error("output register changed outside load");
  chk_cont_restart: assert property ( // [R22]
    state == ST_LOAD && run_mode[MODE_CONT_BIT] && !wr_cfg
      |=> adc_start && clear && state inside {ST_SHUNT, ST_BUS})
    else $error("continuous mode did not restart");
  chk_single_idle: assert property ( // [R23]
    s_single_done |=> state == ST_IDLE && !adc_start)
    else $error("single shot did not go idle");
  chk_trig_start: assert property ( // [R10]
    s_trig_write |=> adc_start && clear && smp_cnt == 11'h000)
    else $error("trigger write did not start a set");
  chk_pd_stay: assert property ( // [R14]
    state == ST_IDLE && cfg_mode[1:0] == 2'b00 && !wr_cfg |=> state == ST_IDLE)
    else $error("left power-down without a mode write");
  chk_wake_time: assert property ( // [R12]
    $fell(state == ST_WAKE) && !$past(wr_cfg)
      |-> adc_start && $past(wake_cnt) == 12'(WAKE_CYC - 1))
    else $error("wake period not honoured");
endmodule
`default_nettype wire

// *** verif/pmcs_adc_model.sv ***
// Behavioural converter that answers the sequencer's start pulses
`timescale 1ns/1ns
`default_nettype none
module pmcs_adc_model #(
  parameter int DELAY = 5
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        adc_start,
  input  wire logic        adc_sel_bus,
  input  wire logic [15:0] shunt_code,
  input  wire logic [15:0] bus_code,
  output logic             adc_done,
  output logic      [15:0] adc_data
);
  int   cnt;
  logic sel;

  // A new start discards any conversion still pending
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt      <= 0;
      sel      <= 1'b0;
      adc_done <= 1'b0;
      adc_data <= 16'h0000;
    end
    else
    begin
      adc_done <= 1'b0;
      // Data is not held outside the done cycle
      adc_data <= ~adc_data;
      if (adc_start)
      begin
        cnt <= DELAY;
        sel <= adc_sel_bus;
      end
      else if (cnt == 1)
      begin
        cnt      <= 0;
        adc_done <= 1'b1;
        adc_data <= sel ? bus_code : shunt_code;
      end
      else if (cnt > 1)
        cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pmcs_pkg::*;
  localparam int TO_CYC = 50;
  logic        sys_clk     = 1'b0;
  logic        resetn      = 1'b0;
  logic        scl_pin     = 1'b1;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [7:0]  reg_addr    = 8'h00;
  logic [15:0] reg_wdata   = 16'h0000;
  logic [15:0] shunt_code  = 16'h0100;
  logic [15:0] bus_code    = 16'h2000;
  logic [15:0] reg_rdata;
  logic [15:0] adc_data;
  logic        adc_done;
  logic        adc_start;
  logic        adc_sel_bus;
  logic [2:0]  adc_conv_time;
  logic [2:0]  ct_sh       = 3'h7;
  logic [2:0]  ct_bus      = 3'h7;
  logic        conversion_ready_flag;
  logic        serial_if_reset;
  int          miscompares = 0;
  int          n_checks    = 0;
  int          n_start     = 0;
  int          n_bus       = 0;
  int          n_sir       = 0;

  always #5 sys_clk = ~sys_clk;

  pmcs_top #(.TIMEOUT_CYC(TO_CYC)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .scl_pin(scl_pin),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .adc_done(adc_done), .adc_data(adc_data), .adc_start(adc_start),
    .adc_sel_bus(adc_sel_bus), .adc_conv_time(adc_conv_time),
    .conversion_ready_flag(conversion_ready_flag),
    .serial_if_reset(serial_if_reset));

  pmcs_adc_model model (
    .sys_clk(sys_clk), .resetn(resetn), .adc_start(adc_start),
    .adc_sel_bus(adc_sel_bus), .shunt_code(shunt_code),
    .bus_code(bus_code), .adc_done(adc_done), .adc_data(adc_data));

  always @(posedge sys_clk)
  begin
    if (adc_start === 1'b1)
      n_start <= n_start + 1;
    if (adc_start === 1'b1 && adc_sel_bus === 1'b1)
      n_bus <= n_bus + 1;
    // Conversion time last requested for each input
    if (adc_start === 1'b1)
    begin
      if (adc_sel_bus === 1'b1)
        ct_bus <= adc_conv_time;
      else
        ct_sh <= adc_conv_time;
    end
    if (serial_if_reset === 1'b1)
      n_sir <= n_sir + 1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic check_flag(input logic exp);
    check({15'h0000, conversion_ready_flag}, {15'h0000, exp});
  endtask

  // Polls a result register while waiting, so reads overlap conversions
  task automatic wait_flag();
    logic [15:0] d;
    int          i;
    i = 0;
    while (conversion_ready_flag !== 1'b1 && i < 5000)
    begin
      rd(ADDR_SHUNT, d);
      i++;
    end
    check_flag(1'b1);
  endtask

  task automatic check_out(input logic [15:0] sh, input logic [15:0] bu,
                           input logic [15:0] cu, input logic [15:0] pw);
    logic [15:0] d;
    rd(ADDR_SHUNT, d);
    check(d, sh);
    rd(ADDR_BUS, d);
    check(d, bu);
    rd(ADDR_CUR, d);
    check(d, cu);
    rd(ADDR_PWR, d);
    check(d, pw);
  endtask

  task automatic t_reset();
    logic [15:0] d;
    rd(ADDR_CFG, d);
    check(d, CFG_RESET);
    rd(ADDR_CAL, d);
    check(d, CAL_RESET);
    rd(8'h07, d);
    check(d, 16'h0000);
    wr(ADDR_SHUNT, 16'h1234);
    rd(ADDR_SHUNT, d);
    check(d, 16'h0000);
    wr(ADDR_MASK, 16'hFFFF);
    rd(ADDR_MASK, d);
    check(d, MASK_RW);
    wr(ADDR_MASK, MASK_RESET);
    check_flag(1'b0);
    $display("test reset done");
  endtask

  task automatic t_cont();
    logic [15:0] d;
    int          s;
    wr(ADDR_CAL, 16'h0800);
    wait_flag();
    check_out(16'h0100, 16'h2000, 16'h0100, 16'h0100);
    rd(ADDR_MASK, d);
    check(d & 16'h0008, 16'h0008);
    check_flag(1'b0);
    s = n_start;
    wait_flag();
    // Let the restarted set issue both of its conversions
    repeat (20) @(posedge sys_clk);
    check({15'h0000, (n_start - s) >= 2}, 16'h0001);
    wr(ADDR_CFG, 16'h0000);
    check_flag(1'b1);
    wr(ADDR_CAL, 16'h0800);
    rd(ADDR_CAL, d);
    check(d, 16'h0800);
    s = n_start;
    repeat (300) @(posedge sys_clk);
    check(16'(n_start - s), 16'h0000);
    $display("test continuous done");
  endtask

  task automatic t_single(input logic [15:0] cfg, input logic [15:0] sh,
                          input logic [15:0] bu, input int starts,
                          input int buses, input logic [15:0] e_sh,
                          input logic [15:0] e_bu, input logic [15:0] e_cu,
                          input logic [15:0] e_pw);
    logic [15:0] d;
    int          i;
    int          s;
    int          b;
    @(posedge sys_clk);
    shunt_code <= sh;
    bus_code   <= bu;
    wr(ADDR_CFG, 16'h0000);
    repeat (20) @(posedge sys_clk);
    s = n_start;
    b = n_bus;
    wr(ADDR_CFG, cfg);
    check_flag(1'b0);
    i = 0;
    while (adc_start !== 1'b1 && i < 6000)
    begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    check({15'h0000, i >= WAKE_CYC - 1}, 16'h0001);
    wait_flag();
    check_out(e_sh, e_bu, e_cu, e_pw);
    check(16'(n_start - s), 16'(starts));
    check(16'(n_bus - b), 16'(buses));
    if (starts > buses)
      check(16'(ct_sh), 16'(cfg[SCT_LSB +: 3]));
    if (buses > 0)
      check(16'(ct_bus), 16'(cfg[BCT_LSB +: 3]));
    repeat (200) @(posedge sys_clk);
    check(16'(n_start - s), 16'(starts));
    rd(ADDR_SHUNT, d);
    check(d, e_sh);
    // Same mode written again while active runs one more set
    wr(ADDR_CFG, cfg);
    wait_flag();
    check(16'(n_start - s), 16'(2 * starts));
    $display("test single %h done", cfg);
  endtask

  task automatic t_timeout();
    @(posedge sys_clk);
    scl_pin <= 1'b0;
    repeat (TO_CYC + 20) @(posedge sys_clk);
    scl_pin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check(16'(n_sir), 16'h0001);
    scl_pin <= 1'b0;
    repeat (TO_CYC - 10) @(posedge sys_clk);
    scl_pin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check(16'(n_sir), 16'h0001);
    $display("test timeout done");
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    t_reset();
    t_cont();
    t_single(16'h0263, 16'h0040, 16'h4000, 8, 4,
             16'h0040, 16'h4000, 16'h0040, 16'h0080);
    t_single(16'h0001, 16'h0080, 16'h4000, 1, 0,
             16'h0080, 16'h4000, 16'h0080, 16'h0080);
    t_single(16'h0002, 16'h0080, 16'h1000, 1, 1,
             16'h0080, 16'h1000, 16'h0080, 16'h0040);
    wr(ADDR_CAL, 16'h0000);
    t_single(16'h0003, 16'h0080, 16'h1000, 2, 1,
             16'h0080, 16'h1000, 16'h0000, 16'h0000);
    t_timeout();
    print_verdict();
  end

  // Full run needs roughly 22000 cycles
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
